/* File: hdl/ioexc_pkg.sv */
package ioexc_pkg;

    // ********************************************************
    // Sizes
    // ********************************************************
    localparam int SM_NUM = 4;
    localparam int PC_W = 5;
    localparam int LVL_W = 3;
    localparam int ADDR_W = 12;

    // ********************************************************
    // Register map, byte addresses
    // ********************************************************
    localparam logic [11:0] OFS_CTRL_BASE = 12'h0CC;
    localparam logic [11:0] OFS_CTRL_STRIDE = 12'h018;

    // ********************************************************
    // Field positions of the execution control register
    // ********************************************************
    localparam int POS_PENDING = 31;
    localparam int POS_SIDE_OPT = 30;
    localparam int POS_SIDE_DIR = 29;
    localparam int POS_PIN_SEL = 24;
    localparam int POS_OE_SEL = 19;
    localparam int POS_INLINE_EN = 18;
    localparam int POS_HOLD = 17;
    localparam int POS_LOOP_END = 12;
    localparam int POS_LOOP_START = 7;
    localparam int POS_CMP_SRC = 4;
    localparam int POS_CMP_LVL = 0;
    localparam int SEL_W = 5;
    localparam int CMP_LVL_W = 4;

    // ********************************************************
    // Reset value and writable bits
    // ********************************************************
    localparam logic [31:0] CTRL_RESET = 32'h0001F000;
    localparam logic [31:0] CTRL_WR_MASK = 32'h7FFFFF9F;

    // ********************************************************
    // Delay/side-set field, status compare source
    // ********************************************************
    localparam int DS_W = 5;
    localparam logic [2:0] SIDE_CNT_MAX = 3'h5;
    localparam logic CMP_SRC_TX = 1'h0;
    localparam logic CMP_SRC_RX = 1'h1;

endpackage

/* File: hdl/ioexc_decode.sv */
module ioexc_decode (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [31:0] ctrl_in,
    input wire logic [2:0] side_cnt_in,
    input wire logic [ioexc_pkg::DS_W-1:0] ds_field_in,
    input wire logic [ioexc_pkg::LVL_W-1:0] tx_level_in,
    input wire logic [ioexc_pkg::LVL_W-1:0] rx_level_in,
    input wire logic [31:0] gpio_in,
    output logic side_en_out,
    output logic [ioexc_pkg::DS_W-1:0] side_data_out,
    output logic side_dir_out,
    output logic [ioexc_pkg::DS_W-1:0] delay_out,
    output logic pin_cond_out,
    output logic status_out
);
    logic [2:0] cnt;
    logic [ioexc_pkg::DS_W-1:0] raw;
    logic [ioexc_pkg::DS_W-1:0] dmask;
    logic [ioexc_pkg::DS_W-1:0] topbit;
    logic opt;
    logic [ioexc_pkg::SEL_W-1:0] pin_sel;
    logic [ioexc_pkg::LVL_W-1:0] lvl;
    logic [ioexc_pkg::CMP_LVL_W-1:0] cmp_n;

    // Counts above five are clamped; the field is only five bits wide
    assign cnt = (side_cnt_in > ioexc_pkg::SIDE_CNT_MAX) ?
                 ioexc_pkg::SIDE_CNT_MAX : side_cnt_in;
    assign opt = ctrl_in[ioexc_pkg::POS_SIDE_OPT];
    assign dmask = 5'(5'h1F >> cnt);
    assign raw = 5'(ds_field_in >> (3'h5 - cnt));
    assign topbit = (cnt == 3'h0) ? 5'h00 : 5'(5'h01 << (cnt - 3'h1));
    assign pin_sel = ctrl_in[ioexc_pkg::POS_PIN_SEL +: ioexc_pkg::SEL_W];
    assign cmp_n = ctrl_in[ioexc_pkg::POS_CMP_LVL +: ioexc_pkg::CMP_LVL_W];
    assign lvl = (ctrl_in[ioexc_pkg::POS_CMP_SRC] == ioexc_pkg::CMP_SRC_RX)
                 ? rx_level_in : tx_level_in;

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            side_en_out <= 1'b0;
            side_data_out <= 5'h00;
            delay_out <= 5'h00;
        end
        else
        begin
            delay_out <= ds_field_in & dmask;
            // Enable bit is one of the counted bits when optional
            if (opt)
            begin
                side_en_out <= |(raw & topbit);
                side_data_out <= raw & ~topbit;
            end
            else
            begin
                side_en_out <= (cnt != 3'h0);
                side_data_out <= raw;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            side_dir_out <= 1'b0;
            pin_cond_out <= 1'b0;
            status_out <= 1'b0;
        end
        else
        begin
            side_dir_out <= ctrl_in[ioexc_pkg::POS_SIDE_DIR];
            // Absolute GPIO number, no input base applied
            pin_cond_out <= gpio_in[pin_sel];
            status_out <= ({1'b0, lvl} < cmp_n);
        end
    end

    chk_side_count_zero: assert property (@(posedge CLK_IN)
        disable iff (!ARST_N_IN) side_cnt_in == 3'h0 |=> !side_en_out)
        else $error("side-set enabled with zero count");
    chk_status_compare: assert property (@(posedge CLK_IN)
        disable iff (!ARST_N_IN)
        ctrl_in[4] && ({1'b0, rx_level_in} < ctrl_in[3:0]) |=> status_out)
        else $error("status compare on receive level wrong");
    chk_pin_cond_sel: assert property (@(posedge CLK_IN)
        disable iff (!ARST_N_IN)
        1'b1 |=> pin_cond_out == $past(gpio_in[ctrl_in[28:24]]))
        else $error("branch pin condition not from selected gpio");
endmodule

/* File: hdl/ioexc_merge.sv */
module ioexc_merge (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [ioexc_pkg::SM_NUM-1:0] act_in,
    input wire logic [ioexc_pkg::SM_NUM*32-1:0] val_in,
    input wire logic [ioexc_pkg::SM_NUM*32-1:0] mask_in,
    output logic [31:0] pin_out,
    output logic [31:0] drv_out
);
    logic [31:0] pin_next;
    logic [31:0] drv_next;

    // Lowest first so that higher machines overwrite
    always_comb
    begin
        pin_next = 32'h00000000;
        drv_next = 32'h00000000;
        for (int i = 0; i < ioexc_pkg::SM_NUM; i++)
        begin
            if (act_in[i])
            begin
                pin_next = (pin_next & ~mask_in[i*32 +: 32]) |
                           (val_in[i*32 +: 32] & mask_in[i*32 +: 32]);
                drv_next = drv_next | mask_in[i*32 +: 32];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            pin_out <= 32'h00000000;
            drv_out <= 32'h00000000;
        end
        else
        begin
            pin_out <= pin_next;
            drv_out <= drv_next;
        end
    end

    chk_top_priority: assert property (@(posedge CLK_IN)
        disable iff (!ARST_N_IN) act_in[3] |=>
        ((pin_out & $past(mask_in[127:96])) ==
         ($past(val_in[127:96]) & $past(mask_in[127:96]))))
        else $error("highest machine does not win pin merge");
endmodule

/* File: hdl/ioexc_top.sv */
// Operation
// - Pending flag set while forced instruction stalls; clears on completion.
// - Optional side-set makes top field bit an enable; width five to four.
// - Side-set count includes the enable bit when side-set is optional.
// - Direction bit sends side-set data to pin directions instead of values.
// - Five-bit field picks absolute GPIO for the branch-on-pin condition.
// - Inline enable uses one selected OUT data bit as pin write enable.
// - Inline plus hold: OUT with enable bit zero withdraws last pin write.
// - Pin writes merged by priority, higher machine overrides lower.
// - Hold bit keeps asserting latest OUT or SET value continuously.
// - After loop end address, counter loads loop start; loop end resets 1F.
// - Taken jump at loop end address wins over wrapping.
// - Loop start is five-bit field, reset zero, loaded on wrap.
// - Status move gives ones if chosen FIFO level below level, else zeros.
// - Status compare level is four bits, reset zero.
// - Each of four machines has its own independent control register.
// - Side-set count picks top bits of field, zero to five; rest delay.
// - Forced instruction runs at once, jumps included, then program resumes.
module ioexc_top (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [ioexc_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    input wire logic [ioexc_pkg::SM_NUM-1:0] FORCE_WR_IN,
    input wire logic [ioexc_pkg::SM_NUM-1:0] FORCE_DONE_IN,
    input wire logic [ioexc_pkg::SM_NUM-1:0] EXEC_IN,
    input wire logic [ioexc_pkg::SM_NUM-1:0] JMP_TAKEN_IN,
    input wire logic [ioexc_pkg::SM_NUM*ioexc_pkg::PC_W-1:0] JMP_TARGET_IN,
    output logic [ioexc_pkg::SM_NUM*ioexc_pkg::PC_W-1:0] PC_OUT,
    input wire logic [ioexc_pkg::SM_NUM*3-1:0] SIDE_CNT_IN,
    input wire logic [ioexc_pkg::SM_NUM*ioexc_pkg::DS_W-1:0] DS_FIELD_IN,
    output logic [ioexc_pkg::SM_NUM-1:0] SIDE_EN_OUT,
    output logic [ioexc_pkg::SM_NUM*ioexc_pkg::DS_W-1:0] SIDE_DATA_OUT,
    output logic [ioexc_pkg::SM_NUM-1:0] SIDE_DIR_OUT,
    output logic [ioexc_pkg::SM_NUM*ioexc_pkg::DS_W-1:0] DELAY_OUT,
    input wire logic [31:0] GPIO_IN,
    output logic [ioexc_pkg::SM_NUM-1:0] PIN_COND_OUT,
    input wire logic [ioexc_pkg::SM_NUM*ioexc_pkg::LVL_W-1:0] TX_LEVEL_IN,
    input wire logic [ioexc_pkg::SM_NUM*ioexc_pkg::LVL_W-1:0] RX_LEVEL_IN,
    output logic [ioexc_pkg::SM_NUM-1:0] STATUS_OUT,
    input wire logic [ioexc_pkg::SM_NUM-1:0] OUT_WR_IN,
    input wire logic [ioexc_pkg::SM_NUM-1:0] SET_WR_IN,
    input wire logic [ioexc_pkg::SM_NUM*32-1:0] PIN_DATA_IN,
    input wire logic [ioexc_pkg::SM_NUM*32-1:0] PIN_MASK_IN,
    output logic [31:0] PIN_OUT,
    output logic [31:0] PIN_DRV_OUT
);
    // ********************************************************
    // Declarations
    // ********************************************************
    localparam int N = ioexc_pkg::SM_NUM;
    localparam int PW = ioexc_pkg::PC_W;

    logic [31:0] ctrl_reg [N];
    logic [N-1:0] pending_reg;
    logic [PW-1:0] pc_reg [N];
    logic [N-1:0] hit;
    logic [N-1:0] act_reg;
    logic [N*32-1:0] val_reg;
    logic [N*32-1:0] mask_reg;
    logic [31:0] rdata_next;
    logic [31:0] ctrl_view [N];

    // ********************************************************
    // Per-machine control, counter and pin write state
    // ********************************************************
    generate
        for (genvar i = 0; i < N; i++)
        begin : g_sm
            logic [PW-1:0] loop_end;
            logic [PW-1:0] loop_start;
            logic [PW-1:0] target;
            logic inline_en;
            logic hold;
            logic [ioexc_pkg::SEL_W-1:0] oe_sel;
            logic [31:0] data;
            logic wr_en;

            assign hit[i] = (REG_ADDR_IN == 12'(ioexc_pkg::OFS_CTRL_BASE +
                            i * ioexc_pkg::OFS_CTRL_STRIDE));
            assign loop_end = ctrl_reg[i][ioexc_pkg::POS_LOOP_END +: PW];
            assign loop_start = ctrl_reg[i][ioexc_pkg::POS_LOOP_START +: PW];
            assign target = JMP_TARGET_IN[i*PW +: PW];
            assign inline_en = ctrl_reg[i][ioexc_pkg::POS_INLINE_EN];
            assign hold = ctrl_reg[i][ioexc_pkg::POS_HOLD];
            assign oe_sel = ctrl_reg[i][ioexc_pkg::POS_OE_SEL +:
                                        ioexc_pkg::SEL_W];
            assign data = PIN_DATA_IN[i*32 +: 32];
            assign wr_en = !inline_en || data[oe_sel];
            assign ctrl_view[i] = {pending_reg[i], ctrl_reg[i][30:0]};

            // Bit 31 and reserved bits 6:5 never take write data
            always_ff @(posedge CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                    ctrl_reg[i] <= ioexc_pkg::CTRL_RESET;
                else if (REG_WR_IN && hit[i])
                    ctrl_reg[i] <= REG_WDATA_IN & ioexc_pkg::CTRL_WR_MASK;
            end

            // New stall wins over a completion in the same cycle
            always_ff @(posedge CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                    pending_reg[i] <= 1'b0;
                else if (FORCE_WR_IN[i])
                    pending_reg[i] <= 1'b1;
                else if (FORCE_DONE_IN[i])
                    pending_reg[i] <= 1'b0;
            end

            // A forced instruction only moves the counter when it jumps
            always_ff @(posedge CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                    pc_reg[i] <= 5'h00;
                else if (pending_reg[i] && FORCE_DONE_IN[i])
                begin
                    if (JMP_TAKEN_IN[i])
                        pc_reg[i] <= target;
                end
                else if (EXEC_IN[i] && !pending_reg[i])
                begin
                    if (JMP_TAKEN_IN[i])
                        pc_reg[i] <= target;
                    else if (pc_reg[i] == loop_end)
                        pc_reg[i] <= loop_start;
                    else
                        pc_reg[i] <= pc_reg[i] + 5'h01;
                end
            end

            // SET always writes; OUT may be gated by its inline bit
            always_ff @(posedge CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                begin
                    act_reg[i] <= 1'b0;
                    val_reg[i*32 +: 32] <= 32'h00000000;
                    mask_reg[i*32 +: 32] <= 32'h00000000;
                end
                else if (SET_WR_IN[i] || (OUT_WR_IN[i] && wr_en))
                begin
                    act_reg[i] <= 1'b1;
                    val_reg[i*32 +: 32] <= data;
                    mask_reg[i*32 +: 32] <= PIN_MASK_IN[i*32 +: 32];
                end
                else if (OUT_WR_IN[i])
                    act_reg[i] <= 1'b0;
                else
                    act_reg[i] <= act_reg[i] && hold;
            end

            always_ff @(posedge CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                    PC_OUT[i*PW +: PW] <= 5'h00;
                else
                    PC_OUT[i*PW +: PW] <= pc_reg[i];
            end

            ioexc_decode u_decode (
                .CLK_IN(CLK_IN),
                .ARST_N_IN(ARST_N_IN),
                .ctrl_in(ctrl_reg[i]),
                .side_cnt_in(SIDE_CNT_IN[i*3 +: 3]),
                .ds_field_in(DS_FIELD_IN[i*ioexc_pkg::DS_W +:
                                         ioexc_pkg::DS_W]),
                .tx_level_in(TX_LEVEL_IN[i*ioexc_pkg::LVL_W +:
                                         ioexc_pkg::LVL_W]),
                .rx_level_in(RX_LEVEL_IN[i*ioexc_pkg::LVL_W +:
                                         ioexc_pkg::LVL_W]),
                .gpio_in(GPIO_IN),
                .side_en_out(SIDE_EN_OUT[i]),
                .side_data_out(SIDE_DATA_OUT[i*ioexc_pkg::DS_W +:
                                             ioexc_pkg::DS_W]),
                .side_dir_out(SIDE_DIR_OUT[i]),
                .delay_out(DELAY_OUT[i*ioexc_pkg::DS_W +:
                                     ioexc_pkg::DS_W]),
                .pin_cond_out(PIN_COND_OUT[i]),
                .status_out(STATUS_OUT[i])
            );

            // ************************************************
            // Checks
            // ************************************************
            chk_pending_set: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                FORCE_WR_IN[i] |=> pending_reg[i])
                else $error("pending flag not set by forced write");
            chk_pending_clear: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                FORCE_DONE_IN[i] && !FORCE_WR_IN[i] |=> !pending_reg[i])
                else $error("pending flag not cleared on completion");
            chk_loop_wrap: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                EXEC_IN[i] && !pending_reg[i] && !JMP_TAKEN_IN[i] &&
                pc_reg[i] == loop_end |=> pc_reg[i] == $past(loop_start))
                else $error("counter did not wrap to loop start");
            chk_jump_wins: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                EXEC_IN[i] && !pending_reg[i] && JMP_TAKEN_IN[i]
                |=> pc_reg[i] == $past(target))
                else $error("taken jump lost to wrap or increment");
            chk_forced_resume: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                pending_reg[i] && !FORCE_DONE_IN[i] |=> $stable(pc_reg[i]))
                else $error("counter moved while forced instruction stalled");
            chk_withdraw_write: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                OUT_WR_IN[i] && !SET_WR_IN[i] && inline_en && hold &&
                !data[oe_sel] |=> !act_reg[i])
                else $error("disabled inline write did not withdraw");
            chk_hold_write: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                act_reg[i] && hold && !OUT_WR_IN[i] && !SET_WR_IN[i]
                && !(REG_WR_IN && hit[i]) |=> act_reg[i] [*1])
                else $error("held pin write dropped");

            chk_inline_gate: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                OUT_WR_IN[i] && inline_en && data[oe_sel] |=> act_reg[i])
                else $error("enabled inline write not taken");

            chk_forced_jump: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                pending_reg[i] && FORCE_DONE_IN[i] && JMP_TAKEN_IN[i]
                |=> pc_reg[i] == $past(target))
                else $error("forced jump did not load its target");

            chk_forced_keep: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                pending_reg[i] && FORCE_DONE_IN[i] && !JMP_TAKEN_IN[i]
                |=> $stable(pc_reg[i]))
                else $error("forced non-jump moved the counter");

            chk_pc_step: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                EXEC_IN[i] && !pending_reg[i] && !JMP_TAKEN_IN[i] &&
                pc_reg[i] != loop_end |=>
                pc_reg[i] == $past(pc_reg[i]) + 5'h01)
                else $error("counter did not step by one");

            chk_one_shot: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                act_reg[i] && !hold && !OUT_WR_IN[i] && !SET_WR_IN[i]
                |=> !act_reg[i])
                else $error("pin write stayed without hold bit");

            chk_ctrl_keep: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                !(REG_WR_IN && hit[i]) |=> $stable(ctrl_reg[i]))
                else $error("control register changed without write");

            chk_pending_read: assert property (@(posedge CLK_IN)
                disable iff (!ARST_N_IN)
                REG_RD_IN && hit[i] |=>
                REG_RDATA_OUT[31] == $past(pending_reg[i]))
                else $error("pending flag missing from read data");
        end
    endgenerate

    // ********************************************************
    // Register read port
    // ********************************************************
    always_comb
    begin
        rdata_next = 32'h00000000;
        for (int i = 0; i < N; i++)
        begin
            if (hit[i])
                rdata_next = ctrl_view[i];
        end
    end

    // Read data stand for exactly one cycle; unmapped reads give zero
    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            REG_RDATA_OUT <= 32'h00000000;
        else if (REG_RD_IN)
            REG_RDATA_OUT <= rdata_next;
        else
            REG_RDATA_OUT <= 32'h00000000;
    end

    // ********************************************************
    // Pin write merge
    // ********************************************************
    ioexc_merge u_merge (
        .CLK_IN(CLK_IN),
        .ARST_N_IN(ARST_N_IN),
        .act_in(act_reg),
        .val_in(val_reg),
        .mask_in(mask_reg),
        .pin_out(PIN_OUT),
        .drv_out(PIN_DRV_OUT)
    );

    chk_ctrl_write: assert property (@(posedge CLK_IN)
        disable iff (!ARST_N_IN)
        REG_WR_IN && hit[1] ##1 REG_RD_IN && hit[1] && !REG_WR_IN |=>
        REG_RDATA_OUT[30:0] == $past(REG_WDATA_IN[30:0] & 31'h7FFFFF9F, 2))
        else $error("control register readback mismatch");

    chk_read_idle: assert property (@(posedge CLK_IN)
        disable iff (!ARST_N_IN)
        !REG_RD_IN |=> REG_RDATA_OUT == 32'h00000000)
        else $error("read data stood past its cycle");
endmodule

/* File: tb/io_state_machine_exec_control_tb.sv */
module io_state_machine_exec_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic arst_n;
    logic reg_wr;
    logic reg_rd;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] gpio;
    logic [31:0] pin_out;
    logic [31:0] pin_drv;
    logic [3:0] force_wr;
    logic [3:0] force_done;
    logic [3:0] exec;
    logic [3:0] jmp_taken;
    logic [3:0] side_en;
    logic [3:0] side_dir;
    logic [3:0] pin_cond;
    logic [3:0] status;
    logic [3:0] out_wr;
    logic [3:0] set_wr;
    logic [19:0] jmp_target;
    logic [19:0] pc;
    logic [19:0] ds_field;
    logic [19:0] side_data;
    logic [19:0] delay;
    logic [11:0] side_cnt;
    logic [11:0] tx_level;
    logic [11:0] rx_level;
    logic [127:0] pin_data;
    logic [127:0] pin_mask;
    int miscompares;
    int num_checks;

    ioexc_top dut (
        .CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(reg_addr),
        .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
        .REG_RDATA_OUT(reg_rdata), .FORCE_WR_IN(force_wr),
        .FORCE_DONE_IN(force_done), .EXEC_IN(exec), .JMP_TAKEN_IN(jmp_taken),
        .JMP_TARGET_IN(jmp_target), .PC_OUT(pc), .SIDE_CNT_IN(side_cnt),
        .DS_FIELD_IN(ds_field), .SIDE_EN_OUT(side_en),
        .SIDE_DATA_OUT(side_data), .SIDE_DIR_OUT(side_dir),
        .DELAY_OUT(delay), .GPIO_IN(gpio), .PIN_COND_OUT(pin_cond),
        .TX_LEVEL_IN(tx_level), .RX_LEVEL_IN(rx_level),
        .STATUS_OUT(status), .OUT_WR_IN(out_wr), .SET_WR_IN(set_wr),
        .PIN_DATA_IN(pin_data), .PIN_MASK_IN(pin_mask), .PIN_OUT(pin_out),
        .PIN_DRV_OUT(pin_drv)
    );

    // ********************************************************
    // Access tasks
    // ********************************************************
    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function logic [11:0] ofs(input int i);
        return ioexc_pkg::OFS_CTRL_BASE + 12'(i) * ioexc_pkg::OFS_CTRL_STRIDE;
    endfunction

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task rdc(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("ctrl", reg_rdata, e);
    endtask

    // Read strobe right behind the write, no idle cycle between
    task wrrd(input logic [11:0] a, input logic [31:0] d,
              input logic [31:0] e);
        wr(a, d);
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("ctrl", reg_rdata, e);
    endtask

    task step(input logic [3:0] ex, input logic [3:0] fd, input logic [3:0] jt,
              input logic [4:0] tgt, input logic [4:0] epc);
        @(posedge clk);
        exec <= ex;
        force_done <= fd;
        jmp_taken <= jt;
        jmp_target[4:0] <= tgt;
        @(posedge clk);
        exec <= 4'h0;
        force_done <= 4'h0;
        jmp_taken <= 4'h0;
        @(posedge clk);
        #1 chk("pc", 32'(pc[4:0]), 32'(epc));
    endtask

    task pw(input int sm, input bit is_set, input logic [31:0] d,
            input logic [31:0] m);
        @(posedge clk);
        pin_data[sm*32 +: 32] <= d;
        pin_mask[sm*32 +: 32] <= m;
        if (is_set)
            set_wr[sm] <= 1'b1;
        else
            out_wr[sm] <= 1'b1;
        @(posedge clk);
        set_wr <= 4'h0;
        out_wr <= 4'h0;
        @(posedge clk);
        #1;
    endtask

    task end_sim;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ********************************************************
    // Clock, watchdog
    // ********************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #200000;
        miscompares++;
        end_sim;
    end

    // ********************************************************
    // Tests
    // ********************************************************
    initial
    begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, gpio} = '0;
        {force_wr, force_done, exec, jmp_taken, jmp_target} = '0;
        {side_cnt, ds_field, tx_level, rx_level, out_wr, set_wr} = '0;
        {pin_data, pin_mask} = '0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++)
            rdc(ofs(i), 32'h0001F000);
        wrrd(ofs(1), 32'hFFFFFFFF, 32'h7FFFFF9F);
        rdc(ofs(0), 32'h0001F000);
        wr(12'h0D0, 32'hFFFFFFFF);
        rdc(12'h0D0, 32'h00000000);
        wr(ofs(0), 32'h00023080);
        wr(ofs(1), 32'h002FF004);
        wr(ofs(3), 32'h6701F012);
        rdc(ofs(3), 32'h6701F012);
        // Wrap window 1..3 on machine 0
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h01);
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h02);
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h03);
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h01);
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h02);
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h03);
        step(4'h1, 4'h0, 4'h1, 5'h09, 5'h09);
        @(posedge clk);
        force_wr <= 4'h1;
        @(posedge clk);
        force_wr <= 4'h0;
        rdc(ofs(0), 32'h80023080);
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h09);
        step(4'h0, 4'h1, 4'h1, 5'h04, 5'h04);
        rdc(ofs(0), 32'h00023080);
        step(4'h1, 4'h0, 4'h0, 5'h00, 5'h05);
        // Decode of machines 2 and 3; direction and status of all four
        @(posedge clk);
        side_cnt <= 12'h35F;
        ds_field <= 20'hB5000;
        gpio <= 32'h00000080;
        rx_level <= 12'h200;
        tx_level <= 12'h018;
        repeat (3) @(posedge clk);
        #1 chk("side_en", 32'(side_en[3:2]), 32'h3);
        chk("side_data2", 32'(side_data[14:10]), 32'h14);
        chk("delay2", 32'(delay[14:10]), 32'h00);
        chk("side_data3", 32'(side_data[19:15]), 32'h00);
        chk("delay3", 32'(delay[19:15]), 32'h06);
        chk("side_dir", 32'(side_dir), 32'h8);
        chk("pin_cond", 32'(pin_cond[3:2]), 32'h2);
        chk("status", 32'(status), 32'hA);
        @(posedge clk);
        ds_field <= 20'h35000;
        gpio <= 32'h0000007F;
        rx_level <= 12'h400;
        tx_level <= 12'h020;
        repeat (3) @(posedge clk);
        #1 chk("side_en", 32'(side_en[3:2]), 32'h1);
        chk("delay3", 32'(delay[19:15]), 32'h06);
        chk("pin_cond", 32'(pin_cond[3:2]), 32'h1);
        chk("status", 32'(status), 32'h0);
        // Pin writes: sticky, override, withdraw, one-cycle
        pw(0, 1'b1, 32'h1, 32'h1);
        chk("pin_out", pin_out, 32'h1);
        repeat (3) @(posedge clk);
        #1 chk("pin_drv", pin_drv, 32'h1);
        pw(1, 1'b0, 32'h20, 32'h1);
        chk("pin_out", pin_out, 32'h0);
        chk("pin_drv", pin_drv, 32'h1);
        pw(1, 1'b0, 32'h00, 32'h1);
        chk("pin_out", pin_out, 32'h1);
        pw(2, 1'b1, 32'h2, 32'h2);
        chk("pin_drv", pin_drv, 32'h3);
        @(posedge clk);
        #1 chk("pin_drv", pin_drv, 32'h1);
        pw(3, 1'b1, 32'h0, 32'h1);
        chk("pin_out", pin_out, 32'h0);
        end_sim;
    end
endmodule
